// ===== src/fpled_top.sv
`timescale 1ns/1ps


module fpled_top #(
	parameter int unsigned TICK_CYCLES = fpled_pkg::TICK_CYCLES
) (
	input wire logic clk, // system clock, 100 MHz
	input wire logic rst, // synchronous reset, high
	input wire logic [fpled_pkg::NUM_STEPS-1:0] stepBusy, // init step in progress
	input wire logic payloadPowerOk, // payload power and supplies on
	input wire logic boardConfigDone, // board configuration finished
	input wire logic logicConfigured, // programmable logic configured
	input wire logic logicConfigFail, // logic configuration failed
	input wire logic [3:0] acqBusy, // acquisition units A..D busy
	input wire logic [1:0] memCalOk, // memory controllers 0,1 functional
	input wire logic [3:0] adcChanCal, // converter channels A..D calibrated
	input wire logic pcieUp, // pcie subsystem running
	input wire logic pcieRstDone, // pcie reset released
	input wire logic userMode, // software selects user mode
	input wire logic [3:0] userLed, // software led values
	input wire logic hsExtractNeg, // extraction negotiation running
	input wire logic hsInsertNeg, // insertion negotiation running
	input wire logic hsAwaitActivation, // waiting for activation
	input wire logic hsReadyRemove, // ready to be removed
	output logic [3:0] led, // front leds 4..1
	output logic boardCfgLed, // board configuration led
	output logic logicCfgLed, // logic configured led
	output logic hotSwapLed // hot-swap led
);

	fpled_pkg::fpled_owner_t ledOwner;
	fpled_pkg::fpled_owner_t next_ledOwner;
	logic [3:0] next_led;
	logic next_boardCfgLed;
	logic next_logicCfgLed;
	logic next_hotSwapLed;
	logic [3:0] initCode;
	logic logicReady;
	logic [3:0] statusLed;

	fpled_blink_if blinkBus ();

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	fpled_blink #(
		.TICK_CYCLES(TICK_CYCLES)
	) blinkGen (
		.clk(clk),
		.rst(rst),
		.blink(blinkBus.src)
	);

	fpled_init_code initEnc (
		.stepBusy(stepBusy),
		.code(initCode)
	);

	// ----------------------------------------------------------------
	// status mode sources
	// ----------------------------------------------------------------
	assign logicReady = boardConfigDone && logicConfigured && !logicConfigFail;

	always_comb
	begin
		statusLed[0] = |acqBusy;
		statusLed[1] = &memCalOk;
		statusLed[2] = &adcChanCal;
		statusLed[3] = pcieUp && pcieRstDone;
	end

	// ----------------------------------------------------------------
	// led owner
	// ----------------------------------------------------------------
	always_comb
	begin
		next_ledOwner = ledOwner;
		case (ledOwner)
			fpled_pkg::OWN_INIT:
			begin
				if (logicReady)
					next_ledOwner = fpled_pkg::OWN_STATUS;
			end
			fpled_pkg::OWN_STATUS:
			begin
				if (!logicReady)
					next_ledOwner = fpled_pkg::OWN_INIT;
				else if (userMode)
					next_ledOwner = fpled_pkg::OWN_USER;
			end
			fpled_pkg::OWN_USER:
			begin
				if (!logicReady)
					next_ledOwner = fpled_pkg::OWN_INIT;
				else if (!userMode)
					next_ledOwner = fpled_pkg::OWN_STATUS;
			end
			default:
			begin
				next_ledOwner = fpled_pkg::OWN_INIT;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			ledOwner <= fpled_pkg::OWN_INIT;
		else
			ledOwner <= next_ledOwner;
	end

	// ----------------------------------------------------------------
	// led outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		case (next_ledOwner)
			fpled_pkg::OWN_INIT:
				next_led = initCode;
			fpled_pkg::OWN_STATUS:
				next_led = statusLed;
			fpled_pkg::OWN_USER:
				next_led = userLed;
			default:
				next_led = fpled_pkg::LED_RESET;
		endcase
	end

	always_comb
	begin
		if (!payloadPowerOk)
			next_boardCfgLed = 1'b0;
		else if (boardConfigDone)
			next_boardCfgLed = 1'b1;
		else
			next_boardCfgLed = blinkBus.slowOn;
	end

	always_comb
	begin
		next_logicCfgLed = logicConfigured && !logicConfigFail;
	end

	// extraction wins over insertion if both claimed
	always_comb
	begin
		if (hsExtractNeg)
			next_hotSwapLed = blinkBus.shortOn;
		else if (hsInsertNeg)
			next_hotSwapLed = blinkBus.longOn;
		else if (hsAwaitActivation || hsReadyRemove)
			next_hotSwapLed = 1'b1;
		else
			next_hotSwapLed = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			led <= fpled_pkg::LED_RESET;
			boardCfgLed <= fpled_pkg::LAMP_RESET;
			logicCfgLed <= fpled_pkg::LAMP_RESET;
			hotSwapLed <= fpled_pkg::LAMP_RESET;
		end
		else
		begin
			led <= next_led;
			boardCfgLed <= next_boardCfgLed;
			logicCfgLed <= next_logicCfgLed;
			hotSwapLed <= next_hotSwapLed;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_INIT_IDLE: assert property (
		(!logicReady && ledOwner == fpled_pkg::OWN_INIT && stepBusy == '0) |=> led == 4'h0)
		else $error("idle init code not shown");
	AST_INIT_SYSCLK: assert property (
		(!logicReady && ledOwner == fpled_pkg::OWN_INIT && stepBusy[0]) |=> led == 4'h1)
		else $error("system clock step code wrong");
	AST_INIT_OSC: assert property (
		(!logicReady && ledOwner == fpled_pkg::OWN_INIT && stepBusy == 9'h004)
		|=> led == 4'h3)
		else $error("oscillator step code wrong");
	AST_INIT_DIST: assert property (
		(!logicReady && ledOwner == fpled_pkg::OWN_INIT && stepBusy == 9'h010)
		|=> led == 4'h5)
		else $error("clock distributor step code wrong");
	AST_INIT_ADC_D: assert property (
		(!logicReady && ledOwner == fpled_pkg::OWN_INIT && stepBusy == 9'h100)
		|=> led == 4'h9)
		else $error("converter D step code wrong");
	AST_STATUS_TAKE: assert property (
		(ledOwner == fpled_pkg::OWN_INIT && logicReady) |=> ledOwner == fpled_pkg::OWN_STATUS)
		else $error("status mode not taken after configuration");
	AST_ACTIVITY: assert property (
		(next_ledOwner == fpled_pkg::OWN_STATUS) |=> led[0] == $past(|acqBusy))
		else $error("activity led wrong");
	AST_MEMCAL: assert property (
		(next_ledOwner == fpled_pkg::OWN_STATUS && memCalOk != 2'h3) |=> !led[1])
		else $error("memory calibration led lit while not functional");
	AST_ADCCAL: assert property (
		(next_ledOwner == fpled_pkg::OWN_STATUS) |=> led[2] == $past(&adcChanCal))
		else $error("converter calibration led wrong");
	AST_KEEPALIVE: assert property (
		(next_ledOwner == fpled_pkg::OWN_STATUS) |=> led[3] == $past(pcieUp && pcieRstDone))
		else $error("keep-alive led wrong");
	AST_USER: assert property (
		(ledOwner != fpled_pkg::OWN_INIT && logicReady && userMode)
		|=> ledOwner == fpled_pkg::OWN_USER)
		else $error("user mode not entered");
	AST_USER_LED: assert property (
		(next_ledOwner == fpled_pkg::OWN_USER) |=> led == $past(userLed))
		else $error("user leds not followed");
	AST_BOARD_LED: assert property (
		!payloadPowerOk |=> !boardCfgLed)
		else $error("board led lit without payload power");
	AST_BOARD_DONE: assert property (
		(payloadPowerOk && boardConfigDone) [*2] |-> ##1 boardCfgLed)
		else $error("board led not steady after configuration");
	AST_LOGIC_LED: assert property (
		logicCfgLed == (!$past(rst) && $past(logicConfigured && !logicConfigFail)))
		else $error("logic configured led wrong");
	AST_HS_ON: assert property (
		(!hsExtractNeg && !hsInsertNeg && (hsAwaitActivation || hsReadyRemove)) |=> hotSwapLed)
		else $error("hot-swap led not on");
	AST_HS_OFF: assert property (
		(!hsExtractNeg && !hsInsertNeg && !hsAwaitActivation && !hsReadyRemove) |=> !hotSwapLed)
		else $error("hot-swap led not off");
	AST_HS_SHORT: assert property (
		hsExtractNeg |=> hotSwapLed == $past(blinkBus.shortOn))
		else $error("hot-swap led not short blinking");
	AST_HS_LONG: assert property (
		(!hsExtractNeg && hsInsertNeg) |=> hotSwapLed == $past(blinkBus.longOn))
		else $error("hot-swap led not long blinking");
	AST_BOARD_BLINK: assert property (
		(payloadPowerOk && !boardConfigDone) |=> boardCfgLed == $past(blinkBus.slowOn))
		else $error("board led not slow blinking");
	AST_LOGIC_FAIL: assert property (
		logicConfigFail |=> !logicCfgLed)
		else $error("logic led lit after failed configuration");

	// ----------------------------------------------------------------
	// checks, init codes, owner, memory calibration led and reset
	// ----------------------------------------------------------------
	AST_INIT_USERCLK: assert property (
		(!logicReady && stepBusy == 9'h002) |=> led == 4'h2)
		else $error("user clock step code wrong");
	AST_INIT_XPOINT: assert property (
		(!logicReady && stepBusy == 9'h008) |=> led == 4'h4)
		else $error("crosspoint step code wrong");
	AST_INIT_ADC_A: assert property (
		(!logicReady && stepBusy == 9'h020) |=> led == 4'h6)
		else $error("converter A step code wrong");
	AST_INIT_ADC_B: assert property (
		(!logicReady && stepBusy == 9'h040) |=> led == 4'h7)
		else $error("converter B step code wrong");
	AST_INIT_ADC_C: assert property (
		(!logicReady && stepBusy == 9'h080) |=> led == 4'h8)
		else $error("converter C step code wrong");
	AST_INIT_LOWEST: assert property (
		(!logicReady && stepBusy == 9'h1f0) |=> led == 4'h5)
		else $error("lowest busy step not shown");
	AST_INIT_HOLD: assert property (
		!logicReady |=> ledOwner == fpled_pkg::OWN_INIT)
		else $error("leds not returned to init code");
	AST_NO_DIRECT_USER: assert property (
		(ledOwner == fpled_pkg::OWN_INIT) |=> ledOwner != fpled_pkg::OWN_USER)
		else $error("user mode entered without status mode");
	AST_MEMCAL_ON: assert property (
		(next_ledOwner == fpled_pkg::OWN_STATUS && memCalOk == 2'h3) |=> led[1])
		else $error("memory calibration led dark while functional");
	AST_RESET_OUT: assert property (
		$past(rst) |-> (led == fpled_pkg::LED_RESET && !boardCfgLed && !hotSwapLed
		&& !logicCfgLed && ledOwner == fpled_pkg::OWN_INIT))
		else $error("outputs not cleared by reset");

	COV_INIT_TO_STATUS: cover property (
		ledOwner == fpled_pkg::OWN_INIT ##1 ledOwner == fpled_pkg::OWN_STATUS);
	COV_STATUS_TO_USER: cover property (
		ledOwner == fpled_pkg::OWN_STATUS ##1 ledOwner == fpled_pkg::OWN_USER);
	COV_USER_BACK: cover property (
		ledOwner == fpled_pkg::OWN_USER ##1 ledOwner == fpled_pkg::OWN_STATUS);
	COV_HS_SHORT: cover property (hsExtractNeg && hotSwapLed ##1 hsExtractNeg && !hotSwapLed);

endmodule : fpled_top

// ===== src/fpled_pkg.sv
package fpled_pkg;

	// ----------------------------------------------------------------
	// initialisation step codes shown on leds 4..1
	// ----------------------------------------------------------------
	localparam logic [3:0] INIT_IDLE = 4'h0;
	localparam logic [3:0] INIT_SYS_CLK = 4'h1;
	localparam logic [3:0] INIT_USER_CLK = 4'h2;
	localparam logic [3:0] INIT_OSC_CTRL = 4'h3;
	localparam logic [3:0] INIT_XPOINT = 4'h4;
	localparam logic [3:0] INIT_CLK_DIST = 4'h5;
	localparam logic [3:0] INIT_ADC_A = 4'h6;
	localparam logic [3:0] INIT_ADC_D = 4'h9;

	// step busy vector bit positions
	localparam int STEP_SYS_CLK = 0;
	localparam int STEP_USER_CLK = 1;
	localparam int STEP_OSC_CTRL = 2;
	localparam int STEP_XPOINT = 3;
	localparam int STEP_CLK_DIST = 4;
	localparam int STEP_ADC_A = 5;
	localparam int NUM_STEPS = 9;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] LED_RESET = 4'h0;
	localparam logic LAMP_RESET = 1'b0;

	// ----------------------------------------------------------------
	// blink timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_TIME_NS = 1000000;
	localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 17;
	localparam int PHASE_W = 10;
	localparam logic [PHASE_W-1:0] BLINK_PERIOD_TICKS = 10'h3e8;
	localparam logic [PHASE_W-1:0] SLOW_ON_TICKS = 10'h1f4;
	localparam logic [PHASE_W-1:0] SHORT_ON_TICKS = 10'h064;
	localparam logic [PHASE_W-1:0] LONG_ON_TICKS = 10'h384;

	// ----------------------------------------------------------------
	// owner of leds 4..1
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OWN_INIT,
		OWN_STATUS,
		OWN_USER
	} fpled_owner_t;

endpackage : fpled_pkg

// ===== src/fpled_blink_if.sv
`timescale 1ns/1ps

interface fpled_blink_if;
	logic slowOn;
	logic shortOn;
	logic longOn;

	modport src (
		output slowOn,
		output shortOn,
		output longOn
	);

	modport snk (
		input slowOn,
		input shortOn,
		input longOn
	);
endinterface : fpled_blink_if

// ===== src/fpled_blink.sv
`timescale 1ns/1ps

module fpled_blink #(
	parameter int unsigned TICK_CYCLES = fpled_pkg::TICK_CYCLES
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	fpled_blink_if.src blink // blink pattern levels
);

	logic [fpled_pkg::TICK_W-1:0] preCnt;
	logic [fpled_pkg::TICK_W-1:0] next_preCnt;
	logic [fpled_pkg::PHASE_W-1:0] phaseCnt;
	logic [fpled_pkg::PHASE_W-1:0] next_phaseCnt;
	logic next_slowOn;
	logic next_shortOn;
	logic next_longOn;

	// ----------------------------------------------------------------
	// prescaler and blink phase
	// ----------------------------------------------------------------
	always_comb
	begin
		next_preCnt = preCnt + 1'b1;
		next_phaseCnt = phaseCnt;
		if (preCnt == fpled_pkg::TICK_W'(TICK_CYCLES - 1))
		begin
			next_preCnt = '0;
			if (phaseCnt == fpled_pkg::BLINK_PERIOD_TICKS - 1'b1)
				next_phaseCnt = '0;
			else
				next_phaseCnt = phaseCnt + 1'b1;
		end
		next_slowOn = next_phaseCnt < fpled_pkg::SLOW_ON_TICKS;
		next_shortOn = next_phaseCnt < fpled_pkg::SHORT_ON_TICKS;
		next_longOn = next_phaseCnt < fpled_pkg::LONG_ON_TICKS;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			preCnt <= '0;
			phaseCnt <= '0;
			blink.slowOn <= 1'b1;
			blink.shortOn <= 1'b1;
			blink.longOn <= 1'b1;
		end
		else
		begin
			preCnt <= next_preCnt;
			phaseCnt <= next_phaseCnt;
			blink.slowOn <= next_slowOn;
			blink.shortOn <= next_shortOn;
			blink.longOn <= next_longOn;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_BLINK_SHORT: assert property (@(posedge clk) disable iff (rst)
		blink.shortOn == (phaseCnt < fpled_pkg::SHORT_ON_TICKS))
		else $error("short blink level does not match phase");
	AST_BLINK_WRAP: assert property (@(posedge clk) disable iff (rst)
		(preCnt == fpled_pkg::TICK_W'(TICK_CYCLES - 1)
		&& phaseCnt == fpled_pkg::BLINK_PERIOD_TICKS - 1'b1) |=> phaseCnt == '0)
		else $error("blink phase did not wrap");
	AST_BLINK_TICK: assert property (@(posedge clk) disable iff (rst)
		preCnt <= fpled_pkg::TICK_W'(TICK_CYCLES - 1))
		else $error("prescaler ran past its end count");

endmodule : fpled_blink

// ===== src/fpled_init_code.sv
`timescale 1ns/1ps

module fpled_init_code (
	input wire logic [fpled_pkg::NUM_STEPS-1:0] stepBusy, // one bit per init step
	output logic [3:0] code // step code, lowest busy step wins
);

	// ----------------------------------------------------------------
	// priority encoder, idle when nothing is busy
	// ----------------------------------------------------------------
	always_comb
	begin
		code = fpled_pkg::INIT_IDLE;
		for (int i = fpled_pkg::NUM_STEPS - 1; i >= 0; i--)
		begin
			if (stepBusy[i])
				code = 4'(i + 1);
		end
	end

endmodule : fpled_init_code

// ===== tb/fpled_operator_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// operator watching one lamp, counts lit cycles in a window
// ----------------------------------------------------------------
module fpled_operator_model (
	input wire logic clk, // system clock
	input wire logic lamp, // observed lamp, lit = 1
	input wire logic measure, // counting window open
	output logic [15:0] onCount // lit cycles seen in the window
);
	logic [15:0] next_onCount;

	always_comb
	begin
		next_onCount = onCount;
		if (!measure)
			next_onCount = 16'h0000;
		else if (lamp === 1'b1)
			next_onCount = onCount + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		onCount <= next_onCount;
	end
endmodule : fpled_operator_model

// ===== tb/front_panel_status_led_logic_tb.sv
`timescale 1ns/1ps

module front_panel_status_led_logic_tb;
	localparam int unsigned TICKS = 4;
	localparam int PERIOD = int'(fpled_pkg::BLINK_PERIOD_TICKS) * TICKS;
	logic clk, rst, payloadPowerOk, boardConfigDone, logicConfigured, logicConfigFail;
	logic pcieUp, pcieRstDone, userMode, measure;
	logic hsExtractNeg, hsInsertNeg, hsAwaitActivation, hsReadyRemove;
	logic [fpled_pkg::NUM_STEPS-1:0] stepBusy;
	logic [3:0] acqBusy, adcChanCal, userLed, led;
	logic [1:0] memCalOk;
	logic boardCfgLed, logicCfgLed, hotSwapLed;
	logic [15:0] boardOn, hsOn;
	int failures, cmpCount;

	fpled_top #(.TICK_CYCLES(TICKS)) u_dut (.clk(clk), .rst(rst), .stepBusy(stepBusy),
		.payloadPowerOk(payloadPowerOk), .boardConfigDone(boardConfigDone),
		.logicConfigured(logicConfigured), .logicConfigFail(logicConfigFail),
		.acqBusy(acqBusy), .memCalOk(memCalOk), .adcChanCal(adcChanCal), .pcieUp(pcieUp),
		.pcieRstDone(pcieRstDone), .userMode(userMode), .userLed(userLed),
		.hsExtractNeg(hsExtractNeg), .hsInsertNeg(hsInsertNeg),
		.hsAwaitActivation(hsAwaitActivation), .hsReadyRemove(hsReadyRemove), .led(led),
		.boardCfgLed(boardCfgLed), .logicCfgLed(logicCfgLed), .hotSwapLed(hotSwapLed));
	fpled_operator_model u_boardEye (.clk(clk), .lamp(boardCfgLed), .measure(measure),
		.onCount(boardOn));
	fpled_operator_model u_hsEye (.clk(clk), .lamp(hotSwapLed), .measure(measure),
		.onCount(hsOn));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] statusLed();
		return {12'h000, pcieUp & pcieRstDone, &adcChanCal, &memCalOk, |acqBusy};
	endfunction : statusLed

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic nextOut();
		@(posedge clk);
		#1;
	endtask : nextOut

	// one full blink period, so the lit count is phase independent
	task automatic measureWindow();
		@(posedge clk);
		measure <= 1'b1;
		repeat (PERIOD) @(posedge clk);
		measure <= 1'b0;
		#1;
	endtask : measureWindow

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [4:0] kb;
		rst = 1'b1; stepBusy = '0; payloadPowerOk = 1'b0; boardConfigDone = 1'b0;
		logicConfigured = 1'b0; logicConfigFail = 1'b0; acqBusy = 4'h0; memCalOk = 2'h0;
		adcChanCal = 4'h0; pcieUp = 1'b0; pcieRstDone = 1'b0; userMode = 1'b1;
		userLed = 4'hf; hsExtractNeg = 1'b0; hsInsertNeg = 1'b0; hsAwaitActivation = 1'b0;
		hsReadyRemove = 1'b0; measure = 1'b0; failures = 0; cmpCount = 0;
		repeat (3) @(posedge clk);
		#1;
		check({9'h000, led, boardCfgLed, logicCfgLed, hotSwapLed}, 16'h0000);
		@(posedge clk);
		rst <= 1'b0;
		// init step codes, user values refused before configuration
		for (int i = 0; i < fpled_pkg::NUM_STEPS; i++)
		begin
			@(posedge clk);
			stepBusy <= 9'(9'h001 << i);
			nextOut();
			check({12'h000, led}, 16'(i + 1));
		end
		@(posedge clk);
		stepBusy <= 9'h1f0;
		nextOut();
		check({12'h000, led}, 16'h0005);
		check({15'h0000, boardCfgLed}, 16'h0000);
		@(posedge clk);
		stepBusy <= 9'h000;
		userMode <= 1'b0;
		boardConfigDone <= 1'b1;
		logicConfigured <= 1'b1;
		logicConfigFail <= 1'b1;
		nextOut();
		check({12'h000, led}, 16'h0000);
		check({15'h0000, logicCfgLed}, 16'h0000);
		@(posedge clk);
		logicConfigFail <= 1'b0;
		nextOut();
		check({15'h0000, logicCfgLed}, 16'h0001);
		check({12'h000, led}, statusLed());
		// status mode sources, one unit or channel at a time
		for (int k = 0; k < 32; k++)
		begin
			kb = k[4:0];
			@(posedge clk);
			acqBusy <= kb[0] ? 4'(4'h1 << kb[2:1]) : 4'h0;
			memCalOk <= kb[2:1];
			adcChanCal <= kb[3] ? 4'hf : 4'hf ^ 4'(4'h1 << kb[2:1]);
			pcieUp <= kb[4] | kb[0];
			pcieRstDone <= kb[4] | kb[1];
			nextOut();
			check({12'h000, led}, statusLed());
		end
		// user mode entered once software sets userMode while the logic is ready
		@(posedge clk);
		memCalOk <= 2'h3;
		adcChanCal <= 4'hf;
		userMode <= 1'b1;
		userLed <= 4'ha;
		nextOut();
		@(posedge clk);
		acqBusy <= 4'h0;
		nextOut();
		check({12'h000, led}, 16'h000a);
		@(posedge clk);
		userLed <= 4'h5;
		nextOut();
		check({12'h000, led}, 16'h0005);
		@(posedge clk);
		logicConfigured <= 1'b0;
		stepBusy <= 9'h100;
		nextOut();
		check({12'h000, led}, 16'h0009);
		check({15'h0000, logicCfgLed}, 16'h0000);
		@(posedge clk);
		logicConfigured <= 1'b1;
		nextOut();
		check({12'h000, led}, statusLed());
		nextOut();
		check({12'h000, led}, 16'h0005);
		@(posedge clk);
		userMode <= 1'b0;
		nextOut();
		check({12'h000, led}, statusLed());
		// reset in mid-run clears every output and returns to init mode, then status mode resumes
		@(posedge clk);
		rst <= 1'b1;
		userMode <= 1'b1;
		nextOut();
		check({9'h000, led, boardCfgLed, logicCfgLed, hotSwapLed}, 16'h0000);
		@(posedge clk);
		rst <= 1'b0;
		userMode <= 1'b0;
		repeat (3) nextOut();
		check({12'h000, led}, statusLed());
		// blink patterns, extraction wins over insertion
		@(posedge clk);
		payloadPowerOk <= 1'b1;
		boardConfigDone <= 1'b0;
		hsExtractNeg <= 1'b1;
		hsInsertNeg <= 1'b1;
		nextOut();
		measureWindow();
		check(boardOn, 16'(int'(fpled_pkg::SLOW_ON_TICKS) * TICKS));
		check(hsOn, 16'(int'(fpled_pkg::SHORT_ON_TICKS) * TICKS));
		@(posedge clk);
		hsExtractNeg <= 1'b0;
		nextOut();
		measureWindow();
		check(hsOn, 16'(int'(fpled_pkg::LONG_ON_TICKS) * TICKS));
		@(posedge clk);
		boardConfigDone <= 1'b1;
		hsInsertNeg <= 1'b0;
		hsAwaitActivation <= 1'b1;
		nextOut();
		check({14'h0000, boardCfgLed, hotSwapLed}, 16'h0003);
		@(posedge clk);
		hsAwaitActivation <= 1'b0;
		hsReadyRemove <= 1'b1;
		nextOut();
		check({15'h0000, hotSwapLed}, 16'h0001);
		@(posedge clk);
		hsReadyRemove <= 1'b0;
		nextOut();
		check({15'h0000, hotSwapLed}, 16'h0000);
		stop_test();
	end
endmodule : front_panel_status_led_logic_tb
